// *** hdl/sft_spi_timing.sv ***
// Purpose: Device side of the serial flash link: command capture, status output,
//          power-down states and timed internal operations.
// Assumes: Link pins are asynchronous and sampled by the 40 MHz core clock.
// Notes: Only the status read drives data out; array contents are not modelled.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Lockdown freeze completes within 100 us after chip select rises.
// - Ultra-deep power-down is entered within 4 us after chip select rises.
// - Chip select low wakes ultra-deep power-down; ready within 180 us.
// - Deep power-down entered within 2 us; resume completes within 35 us.
// - Page-to-buffer transfer and compare each complete within 200 us.
// - Protection turns on within 1 us of write-protect falling.
// - Protection turns off within 1 us of write-protect rising.
// - Erase-and-program of a page takes typically 17 ms, at most 35 ms.
// - Security register programming takes typically 200 us, at most 500 us.
// - Device launches output on falling clock edges, captures input on rising.
// - Clock level at chip select fall selects mode 0 or mode 3.
// - Output bit is valid while the clock is still low.
module sft_spi_timing #(
   parameter int EP_CYCLES = sft_pkg::EP_CYC,
   parameter int XUDPD_CYCLES = sft_pkg::XUDPD_CYC,
   parameter int XFR_CYCLES = sft_pkg::XFR_CYC,
   parameter int OTPP_CYCLES = sft_pkg::OTPP_CYC
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic sck_i,
   input wire logic cs_n_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   output logic so_o,
   output logic so_oe_o,
   output logic busy_o,
   output logic prot_o,
   output logic lock_frozen_o,
   output logic mode3_o,
   output sft_pkg::sft_pwr_e pwr_o
);
   import sft_pkg::*;

   localparam int A_UDPD_MAX = EUDPD_CYC + 1;
   localparam int A_DPD_MAX = EDPD_CYC + 1;
   localparam int A_WAKE_MAX = RDPD_CYC + 1;

   logic sck_s1, sck_s2, sck_q3;
   logic cs_s1, cs_s2, cs_q3;
   logic si_s1, si_s2;
   logic wp_s1, wp_s2;
   logic sck_rise, sck_fall, cs_fall, cs_rise;
   logic [2:0] bit_cnt_q;
   logic [6:0] sh_q;
   logic [7:0] opc_q;
   logic opc_ok_q;
   logic mode3_q;
   logic [2:0] out_idx_q;
   logic so_q;
   logic prot_q;
   logic lock_frozen_q;
   sft_pwr_e pwr_q;
   sft_op_e op_q;
   sft_op_e start_op;
   logic [TW-1:0] start_len;
   logic [7:0] status;
   logic stat_rd;
   logic [TW-1:0] resume_cnt_q;

   sft_tmr_if tmr ();

   sft_timer u_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .t(tmr.tmr)
   );

   // Two-stage synchronisers; the third stage only feeds edge detection.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         {sck_s1, sck_s2, sck_q3} <= 3'h0;
         {cs_s1, cs_s2, cs_q3} <= 3'h7;
         {si_s1, si_s2} <= 2'h0;
         {wp_s1, wp_s2} <= 2'h3;
      end else begin
         {sck_s1, sck_s2, sck_q3} <= {sck_i, sck_s1, sck_s2};
         {cs_s1, cs_s2, cs_q3} <= {cs_n_i, cs_s1, cs_s2};
         {si_s1, si_s2} <= {si_i, si_s1};
         {wp_s1, wp_s2} <= {wp_n_i, wp_s1};
      end
   end

   assign sck_rise = sck_s2 & ~sck_q3 & ~cs_s2;
   assign sck_fall = ~sck_s2 & sck_q3 & ~cs_s2;
   assign cs_fall = ~cs_s2 & cs_q3;
   assign cs_rise = cs_s2 & ~cs_q3;

   // Idle clock level at select time picks the mode; both are accepted.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         mode3_q <= 1'b0;
      end else if (cs_fall) begin
         mode3_q <= sck_s2;
      end
   end

   // Input bits are taken on rising clock edges only.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         bit_cnt_q <= 3'h0;
         sh_q <= 7'h00;
         opc_q <= 8'h00;
         opc_ok_q <= 1'b0;
      end else if (cs_fall) begin
         bit_cnt_q <= 3'h0;
         opc_ok_q <= 1'b0;
      end else if (sck_rise) begin
         sh_q <= {sh_q[5:0], si_s2};
         bit_cnt_q <= bit_cnt_q + 3'h1;
         if (bit_cnt_q == 3'h7 && !opc_ok_q) begin
            opc_q <= {sh_q, si_s2};
            opc_ok_q <= 1'b1;
         end
      end
   end

   assign status = {~busy_o, 5'h00, prot_q, mode3_q};
   assign stat_rd = opc_ok_q && opc_q == OPC_STATUS && pwr_q == SFT_PWR_ACT;

   // Output bits change on falling edges, so each is valid across the following
   // low phase; a mode 3 select sees its first falling edge before any opcode and
   // therefore shifts nothing out there.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         out_idx_q <= 3'h7;
         so_q <= 1'b0;
      end else if (cs_fall) begin
         out_idx_q <= 3'h7;
      end else if (sck_fall && stat_rd) begin
         so_q <= status[out_idx_q];
         out_idx_q <= out_idx_q - 3'h1;
      end
   end

   assign so_o = so_q;
   assign so_oe_o = ~cs_s2 & stat_rd;

   // Protection follows the synchronised pin within a few cycles, far inside 1 us.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prot_q <= 1'b0;
      end else begin
         prot_q <= ~wp_s2;
      end
   end

   // Decode a whole-byte command at deselect into a timed operation.
   always_comb begin
      start_op = SFT_OP_NONE;
      start_len = '0;
      if (tmr.busy) begin
         start_op = SFT_OP_NONE;
      end else if (pwr_q == SFT_PWR_UDPD && cs_fall) begin
         start_op = SFT_OP_WAKE;
         start_len = TW'(XUDPD_CYCLES);
      end else if (cs_rise && opc_ok_q && bit_cnt_q == 3'h0) begin
         if (pwr_q == SFT_PWR_DPD) begin
            if (opc_q == OPC_RESUME) begin
               start_op = SFT_OP_WAKE;
               start_len = TW'(RDPD_CYC);
            end
         end else if (pwr_q == SFT_PWR_ACT) begin
            case (opc_q)
               OPC_LOCK: begin
                  start_op = SFT_OP_LOCK;
                  start_len = TW'(LOCK_CYC);
               end
               OPC_UDPD: begin
                  start_op = SFT_OP_UDPD;
                  start_len = TW'(EUDPD_CYC);
               end
               OPC_DPD: begin
                  start_op = SFT_OP_DPD;
                  start_len = TW'(EDPD_CYC);
               end
               OPC_XFR, OPC_COMP: begin
                  start_op = SFT_OP_ARRAY;
                  start_len = TW'(XFR_CYCLES);
               end
               OPC_EP: begin
                  start_op = SFT_OP_ARRAY;
                  start_len = TW'(EP_CYCLES);
               end
               OPC_OTPP: begin
                  start_op = SFT_OP_ARRAY;
                  start_len = TW'(OTPP_CYCLES);
               end
               default: begin
                  start_op = SFT_OP_NONE;
               end
            endcase
         end
      end
   end

   assign tmr.start = (start_op != SFT_OP_NONE);
   assign tmr.load = start_len;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         op_q <= SFT_OP_NONE;
      end else if (tmr.start) begin
         op_q <= start_op;
      end else if (tmr.done) begin
         op_q <= SFT_OP_NONE;
      end
   end

   // Power state and lockdown change only when their timed operation ends.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pwr_q <= SFT_PWR_ACT;
         lock_frozen_q <= 1'b0;
      end else if (tmr.done) begin
         case (op_q)
            SFT_OP_LOCK: lock_frozen_q <= 1'b1;
            SFT_OP_UDPD: pwr_q <= SFT_PWR_UDPD;
            SFT_OP_DPD: pwr_q <= SFT_PWR_DPD;
            SFT_OP_WAKE: pwr_q <= SFT_PWR_ACT;
            default: pwr_q <= pwr_q;
         endcase
      end
   end

   assign busy_o = tmr.busy;
   assign prot_o = prot_q;
   assign lock_frozen_o = lock_frozen_q;
   assign mode3_o = mode3_q;
   assign pwr_o = pwr_q;

   // Cycles since a resume started. The resume is longer than a delay range may
   // reach, so its bound is checked on this counter instead.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         resume_cnt_q <= '0;
      end else if (tmr.start && pwr_q == SFT_PWR_DPD) begin
         resume_cnt_q <= TW'(1);
      end else if (pwr_q == SFT_PWR_ACT) begin
         resume_cnt_q <= '0;
      end else if (resume_cnt_q != '0) begin
         resume_cnt_q <= resume_cnt_q + 1'b1;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_mode_capture: assert property (cs_fall |=> mode3_q == $past(sck_s2))
      else $error("Mode not taken from clock level at select.");
   a_out_on_fall: assert property (!$stable(so_q) |-> $past(sck_fall))
      else $error("Output bit changed without a falling clock edge.");
   a_in_on_rise: assert property ($rose(opc_ok_q) |-> $past(sck_rise))
      else $error("Opcode completed without a rising clock edge.");
   a_prot_on: assert property ($fell(wp_s2) |=> prot_o)
      else $error("Protection not enabled after write-protect fell.");
   a_prot_off: assert property ($rose(wp_s2) |=> !prot_o)
      else $error("Protection not removed after write-protect rose.");
   a_udpd_entry: assert property ((tmr.start && start_op == SFT_OP_UDPD) |->
      ##[1:A_UDPD_MAX] pwr_q == SFT_PWR_UDPD)
      else $error("Ultra-deep power-down not entered in time.");
   a_dpd_entry: assert property ((tmr.start && start_op == SFT_OP_DPD) |->
      ##[1:A_DPD_MAX] pwr_q == SFT_PWR_DPD)
      else $error("Deep power-down not entered in time.");
   a_dpd_resume: assert property (resume_cnt_q <= TW'(A_WAKE_MAX))
      else $error("Resume from deep power-down too slow.");
   a_udpd_wake: assert property ((pwr_q == SFT_PWR_UDPD && cs_fall) |=> busy_o)
      else $error("Select low did not start ultra-deep wake.");
   a_lock_set: assert property ((tmr.done && op_q == SFT_OP_LOCK) |=> lock_frozen_q)
      else $error("Lockdown not frozen at end of its operation.");
   a_busy_status: assert property ((sck_fall && stat_rd && out_idx_q == 3'(ST_READY) && busy_o)
      |=> !so_o)
      else $error("Status shows ready while an operation runs.");

   c_mode3_sel: cover property (cs_fall && sck_s2);
   c_status_read: cover property (sck_fall && stat_rd);
   c_udpd_wake: cover property (tmr.done && op_q == SFT_OP_WAKE);
   c_lock_done: cover property (tmr.done && op_q == SFT_OP_LOCK);
endmodule
`default_nettype wire

// *** hdl/sft_pkg.sv ***
// Purpose: Shared constants for the serial flash timing and power block.
// Assumes: Core clock of 40 MHz; all timed figures except the two maxima are converted to core cycles here.
// Notes: Pin inputs pass two flip-flops and one edge stage, so timed counts are trimmed
//        by that latency to keep every completion inside its documented maximum.
package sft_pkg;
   localparam int CLK_MHZ = 40;
   localparam int SYNC_LAT = 3;
   localparam int TW = 21;

   // Times as printed, microseconds unless the name says otherwise.
   localparam int T_LOCK_US = 100;
   localparam int T_EUDPD_US = 4;
   localparam int T_XUDPD_US = 180;
   localparam int T_EDPD_US = 2;
   localparam int T_RDPD_US = 35;
   localparam int T_XFR_US = 200;
   localparam int T_OTPP_TYP_US = 200;
   localparam int T_OTPP_MAX_US = 500;
   localparam int T_EP_TYP_MS = 17;
   localparam int T_EP_MAX_MS = 35;
   localparam int T_WP_US = 1;

   localparam int LOCK_CYC = T_LOCK_US * CLK_MHZ - SYNC_LAT;
   localparam int EUDPD_CYC = T_EUDPD_US * CLK_MHZ - SYNC_LAT;
   localparam int XUDPD_CYC = T_XUDPD_US * CLK_MHZ - SYNC_LAT;
   localparam int EDPD_CYC = T_EDPD_US * CLK_MHZ - SYNC_LAT;
   localparam int RDPD_CYC = T_RDPD_US * CLK_MHZ - SYNC_LAT;
   localparam int XFR_CYC = T_XFR_US * CLK_MHZ - SYNC_LAT;
   localparam int OTPP_CYC = T_OTPP_TYP_US * CLK_MHZ - SYNC_LAT;
   localparam int EP_CYC = T_EP_TYP_MS * 1000 * CLK_MHZ - SYNC_LAT;
   localparam int WP_CYC = T_WP_US * CLK_MHZ - SYNC_LAT;

   // Command codes.
   localparam logic [7:0] OPC_LOCK = 8'h7F;
   localparam logic [7:0] OPC_UDPD = 8'h79;
   localparam logic [7:0] OPC_DPD = 8'hB9;
   localparam logic [7:0] OPC_RESUME = 8'hAB;
   localparam logic [7:0] OPC_XFR = 8'h53;
   localparam logic [7:0] OPC_COMP = 8'h60;
   localparam logic [7:0] OPC_EP = 8'h82;
   localparam logic [7:0] OPC_OTPP = 8'h9B;
   localparam logic [7:0] OPC_STATUS = 8'hD7;

   // Status byte fields.
   localparam int ST_READY = 7;
   localparam int ST_PROT = 1;
   localparam int ST_MODE3 = 0;

   typedef enum logic [1:0] {
      SFT_PWR_ACT = 2'b00,
      SFT_PWR_DPD = 2'b01,
      SFT_PWR_UDPD = 2'b10
   } sft_pwr_e;

   typedef enum logic [2:0] {
      SFT_OP_NONE = 3'b000,
      SFT_OP_LOCK = 3'b001,
      SFT_OP_UDPD = 3'b010,
      SFT_OP_DPD = 3'b011,
      SFT_OP_WAKE = 3'b100,
      SFT_OP_ARRAY = 3'b101
   } sft_op_e;
endpackage

// *** hdl/sft_tmr_if.sv ***
// Purpose: Carries the start request and status of the operation timer.
// Assumes: One timed operation at a time.
// Notes: done is a one-cycle pulse in the last busy cycle.
`timescale 1ns/1ps
`default_nettype none
interface sft_tmr_if;
   logic start;
   logic [sft_pkg::TW-1:0] load;
   logic busy;
   logic done;
   modport ctl (output start, output load, input busy, input done);
   modport tmr (input start, input load, output busy, output done);
endinterface
`default_nettype wire

// *** hdl/sft_timer.sv ***
// Purpose: Down-counter that times one internal operation.
// Assumes: start is only raised while the counter is idle.
// Notes: A load of N keeps busy high for exactly N cycles.
`timescale 1ns/1ps
`default_nettype none
module sft_timer (
   input wire logic mclk_i,
   input wire logic rst_i,
   sft_tmr_if.tmr t
);
   import sft_pkg::*;

   logic [TW-1:0] cnt_q;
   logic [TW-1:0] run_q;
   logic [TW-1:0] len_q;

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_q <= '0;
      end else if (t.start) begin
         cnt_q <= t.load;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   assign t.busy = (cnt_q != '0);
   assign t.done = (cnt_q == TW'(1));

   // Helper logic read only by the checks below.
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         run_q <= '0;
         len_q <= '0;
      end else if (t.start) begin
         run_q <= TW'(1);
         len_q <= t.load;
      end else if (t.busy) begin
         run_q <= run_q + 1'b1;
      end
   end

   a_timer_len: assert property (@(posedge mclk_i) disable iff (rst_i)
      t.done |-> run_q == len_q)
      else $error("Timed operation length differs from its load.");
endmodule
`default_nettype wire

// *** dv/sft_host_model.sv ***
// Purpose: Host controller model that masters the flash link.
// Assumes: Link clock of 200 ns made from 8 core cycles; pins move 1 ns after a core edge.
// Notes: Partial transfers are offered as well; the bench chooses the opcode and bit count.
`timescale 1ns/1ps
`default_nettype none
module sft_host_model (
   input wire logic mclk_i,
   input wire logic so_i,
   output logic sck_o,
   output logic cs_n_o,
   output logic si_o
);
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
      si_o = 1'b0;
   end

   task automatic half();
      repeat (4) @(posedge mclk_i);
      #1;
   endtask

   // The first bit is set up at select; each later bit follows the rise that
   // takes the one before it, a core cycle late, so the device's sampled copy
   // of that rise never meets data that is already changing.
   task automatic xfer(input logic [7:0] op, input int nb, input logic m3,
                       output logic [7:0] rd);
      int n;
      n = nb + ((op == sft_pkg::OPC_STATUS) ? 8 : 0);
      rd = 8'h00;
      sck_o = m3;
      half();
      cs_n_o = 1'b0;
      si_o = op[7];
      half();
      for (int k = 0; k <= n; k++) begin
         // A fall after the last rise is only wanted when a reply bit is taken.
         if (sck_o && (k < n || n > 8)) begin
            sck_o = 1'b0;
            if (k > 8) rd[16 - k] = so_i;
         end
         if (k < n) begin
            half();
            sck_o = 1'b1;
            @(posedge mclk_i);
            #1;
            si_o = (k + 1 < nb) ? op[6 - k] : ~si_o;
            repeat (3) @(posedge mclk_i);
            #1;
         end
      end
      half();
      sck_o = m3;
      half();
      cs_n_o = 1'b1;
      si_o = ~si_o;
   endtask

   // One core cycle of select is above the minimum low time and is still seen
   // by the device's sampling clock.
   task automatic wake();
      cs_n_o = 1'b0;
      @(posedge mclk_i);
      #1;
      cs_n_o = 1'b1;
   endtask
endmodule
`default_nettype wire

// *** dv/sft_spi_timing_test.sv ***
// Purpose: Self-checking bench for the serial flash timing and power block.
// Assumes: Long operations are shortened through the top module's parameters.
// Notes: Durations are counted in core cycles from the chip select rise, from its fall for the wake, and from the pin change for protection.
`timescale 1ns/1ps
`default_nettype none
module sft_spi_timing_test;
   import sft_pkg::*;
   localparam int EP_P = 2000;
   localparam int XU_P = 50;
   localparam int XF_P = 40;
   localparam int OT_P = 40;
   typedef struct {logic [7:0] op; int bsy; int lim; sft_pwr_e pwr;} sft_row_s;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic wp_n = 1'b1;
   logic sck, cs_n, si, so, so_oe, busy, prot, frozen, mode3;
   sft_pwr_e pwr;
   int mismatches = 0;
   int num_checks = 0;
   int tot, bsy, n;
   logic [7:0] rd;
   sft_row_s rows [8] = '{
      '{OPC_XFR, XF_P, T_XFR_US * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_COMP, XF_P, T_XFR_US * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_OTPP, OT_P, T_OTPP_MAX_US * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_EP, EP_P, T_EP_MAX_MS * 1000 * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_LOCK, LOCK_CYC, T_LOCK_US * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_DPD, EDPD_CYC, T_EDPD_US * CLK_MHZ, SFT_PWR_DPD},
      '{OPC_RESUME, RDPD_CYC, T_RDPD_US * CLK_MHZ, SFT_PWR_ACT},
      '{OPC_UDPD, EUDPD_CYC, T_EUDPD_US * CLK_MHZ, SFT_PWR_UDPD}};

   always #12.5 mclk = ~mclk;

   sft_spi_timing #(.EP_CYCLES(EP_P), .XUDPD_CYCLES(XU_P), .XFR_CYCLES(XF_P),
      .OTPP_CYCLES(OT_P)) i_dut (.mclk_i(mclk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n),
      .si_i(si), .wp_n_i(wp_n), .so_o(so), .so_oe_o(so_oe), .busy_o(busy), .prot_o(prot),
      .lock_frozen_o(frozen), .mode3_o(mode3), .pwr_o(pwr));

   // A released output shows the inverse, so a late or missing enable is caught.
   sft_host_model host (.mclk_i(mclk), .so_i(so_oe ? so : ~so), .sck_o(sck), .cs_n_o(cs_n),
      .si_o(si));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Stops at the first edge that finds busy low after it was high, or when the bound runs out.
   task automatic settle(input int lim);
      tot = 0;
      bsy = 0;
      while (tot < lim && !(bsy > 0 && busy === 1'b0)) begin
         @(posedge mclk);
         #1;
         tot++;
         if (busy === 1'b1) bsy++;
      end
   endtask

   task automatic wait_prot(input logic v);
      n = 0;
      while (n < 50 && prot !== v) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      #2_000_000;
      mismatches++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge mclk);
      #1 rst = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      chk({busy, prot, frozen, mode3, so_oe}, 0);
      chk(pwr, SFT_PWR_ACT);
      $display("test reset done");
      foreach (rows[i]) begin
         host.xfer(rows[i].op, 8, i[0], rd);
         settle(rows[i].lim + 2);
         chk(bsy, rows[i].bsy);
         chk(tot <= rows[i].lim + 1, 1);
         chk(pwr, rows[i].pwr);
         chk(mode3, i[0]);
      end
      chk(frozen, 1);
      $display("test table done");
      host.wake();
      settle(T_XUDPD_US * CLK_MHZ + 2);
      chk(bsy, XU_P);
      chk(tot + 1 <= T_XUDPD_US * CLK_MHZ, 1);
      chk(pwr, SFT_PWR_ACT);
      $display("test wake done");
      host.xfer(OPC_STATUS, 8, 1'b0, rd);
      chk(rd, 8'h80);
      host.xfer(OPC_STATUS, 8, 1'b1, rd);
      chk(rd, 8'h81);
      wp_n = 1'b0;
      wait_prot(1'b1);
      chk(n <= T_WP_US * CLK_MHZ, 1);
      host.xfer(OPC_STATUS, 8, 1'b0, rd);
      chk(rd, 8'h82);
      wp_n = 1'b1;
      wait_prot(1'b0);
      chk(n <= T_WP_US * CLK_MHZ, 1);
      $display("test status done");
      host.xfer(OPC_EP, 8, 1'b0, rd);
      host.xfer(OPC_STATUS, 8, 1'b0, rd);
      chk(rd, 8'h00);
      host.xfer(OPC_DPD, 8, 1'b0, rd);
      settle(EP_P + 2);
      chk(pwr, SFT_PWR_ACT);
      host.xfer(OPC_XFR, 4, 1'b0, rd);
      settle(200);
      chk(bsy, 0);
      $display("test refuse done");
      host.xfer(OPC_DPD, 8, 1'b0, rd);
      settle(T_EDPD_US * CLK_MHZ + 2);
      host.xfer(OPC_XFR, 8, 1'b0, rd);
      settle(200);
      chk(bsy, 0);
      chk(pwr, SFT_PWR_DPD);
      host.xfer(OPC_RESUME, 8, 1'b0, rd);
      settle(T_RDPD_US * CLK_MHZ + 2);
      chk(pwr, SFT_PWR_ACT);
      $display("test deep done");
      @(posedge mclk);
      #1 rst = 1'b1;
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      chk({busy, prot, frozen, mode3, so_oe}, 0);
      chk(pwr, SFT_PWR_ACT);
      $display("test rereset done");
      conclude();
   end
endmodule
`default_nettype wire
